// [src/lps_pkg.sv]
package lps_pkg;

    // clock
    localparam int unsigned CLK_KHZ = 40000;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] EVENT_OFS  = 8'h08;

    // control fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

    // event and status bit positions
    localparam int unsigned EV_UV    = 0;
    localparam int unsigned EV_PEAK  = 1;
    localparam int unsigned EV_MAXON = 2;
    localparam int unsigned EV_SHORT = 3;
    localparam int unsigned EV_OVP   = 4;
    localparam int unsigned EV_HEAT  = 5;
    localparam int unsigned EV_MAINS = 6;
    localparam int unsigned EV_W     = 7;
    localparam int unsigned ST_GATE  = 8;
    localparam int unsigned ST_HV    = 9;
    localparam int unsigned ST_STBY  = 10;
    localparam int unsigned ST_TMR   = 11;

    // times as printed, ns or ms
    localparam int unsigned LEB_NS        = 600;
    localparam int unsigned MAXON_NS      = 14400;
    localparam int unsigned OFF_LIMIT_NS  = 20000;
    localparam int unsigned BACKOFF_MS    = 1000;
    localparam int unsigned SH_BACKOFF_MS = 9000;
    localparam int unsigned SH_DET_MS     = 50;
    localparam int unsigned MAINS_LOSS_MS = 50;

    // cycle counts: least times round up, longest round down
    localparam logic [15:0] LEB_CYC =
        16'((LEB_NS * CLK_KHZ + 999_999) / 1_000_000);
    localparam logic [15:0] MAXON_CYC =
        16'((MAXON_NS * CLK_KHZ) / 1_000_000);
    localparam logic [15:0] OFF_LIMIT_CYC =
        16'((OFF_LIMIT_NS * CLK_KHZ) / 1_000_000);
    localparam logic [31:0] BACKOFF_CYC    = 32'(BACKOFF_MS * CLK_KHZ);
    localparam logic [31:0] SH_BACKOFF_CYC = 32'(SH_BACKOFF_MS * CLK_KHZ);
    localparam logic [31:0] SH_DET_CYC     = 32'(SH_DET_MS * CLK_KHZ);
    localparam logic [31:0] MAINS_LOSS_CYC = 32'(MAINS_LOSS_MS * CLK_KHZ);

    // number of synchronised comparator flags
    localparam int unsigned NSYNC = 9;

    typedef enum logic [1:0] {UV_OK, UV_WAIT_START, UV_BACKOFF} lps_uv_t;
    typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_SEC} lps_phase_t;
    typedef enum logic [0:0] {SH_NONE, SH_BACKOFF} lps_short_t;

endpackage

// [src/lps_sync.sv]
`timescale 1ns/1ps
module lps_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // raw and filtered flags
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    s1      <= 1'b0;
                    s2      <= 1'b0;
                    s3      <= 1'b0;
                    dout[i] <= 1'b0;
                end
                else
                begin
                    s1 <= din[i];
                    s2 <= s1;
                    s3 <= s2;
                    // a change counts only once two late stages agree
                    if (s2 == s3)
                        dout[i] <= s3;
                end
            end
        end
    endgenerate

endmodule

// [src/lps_sequencer.sv]
`timescale 1ns/1ps
module lps_sequencer #(
    parameter logic [31:0] BACKOFF_CYC    = lps_pkg::BACKOFF_CYC,
    parameter logic [31:0] SH_BACKOFF_CYC = lps_pkg::SH_BACKOFF_CYC,
    parameter logic [31:0] SH_DET_CYC     = lps_pkg::SH_DET_CYC,
    parameter logic [31:0] MAINS_LOSS_CYC = lps_pkg::MAINS_LOSS_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // regulation loop
    input  wire logic        switch_request,
    // analog comparator flags, asynchronous
    input  wire logic        supply_stop_level,
    input  wire logic        supply_start_level,
    input  wire logic        supply_low_level,
    input  wire logic        supply_over_level,
    input  wire logic        current_sense_input,
    input  wire logic        valley_detect,
    input  wire logic        heat_trip_level,
    input  wire logic        heat_release_level,
    input  wire logic        mains_sense_input,
    // drive and supply control
    output logic             gate_drive_out,
    output logic             hv_source_en,
    output logic             standby_out
);

    logic [lps_pkg::NSYNC-1:0] raw_in;
    logic [lps_pkg::NSYNC-1:0] flt;
    logic stop_f;
    logic start_f;
    logic low_f;
    logic over_f;
    logic peak_f;
    logic valley_f;
    logic trip_f;
    logic release_f;
    logic mains_f;

    assign raw_in = {mains_sense_input, heat_release_level, heat_trip_level,
                     valley_detect, current_sense_input, supply_over_level,
                     supply_low_level, supply_start_level, supply_stop_level};

    lps_sync #(
        .WIDTH (lps_pkg::NSYNC)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (raw_in),
        .dout (flt)
    );

    assign stop_f    = flt[0];
    assign start_f   = flt[1];
    assign low_f     = flt[2];
    assign over_f    = flt[3];
    assign peak_f    = flt[4];
    assign valley_f  = flt[5];
    assign trip_f    = flt[6];
    assign release_f = flt[7];
    assign mains_f   = flt[8];

    lps_pkg::lps_uv_t    uv_state;
    lps_pkg::lps_phase_t phase;
    lps_pkg::lps_phase_t next_phase;
    lps_pkg::lps_short_t sh_state;
    logic [31:0] uv_cnt;
    logic [31:0] sh_cnt;
    logic [31:0] sh_back_cnt;
    logic [31:0] mains_cnt;
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic        sh_run;
    logic        ovp_latch;
    logic        heat_stop;
    logic        mains_stop;
    logic        mains_d;
    logic        run_enable;
    logic [lps_pkg::EV_W-1:0] events;
    logic [lps_pkg::EV_W-1:0] ev_set;
    logic [lps_pkg::EV_W-1:0] ev_clr;

    logic any_stop;
    logic leb_done;
    logic peak_hit;
    logic maxon_hit;
    logic off_timeout;
    logic valley_ok;
    logic sh_trip;
    logic crossing;
    logic mains_trip;
    logic uv_enter;

    // undervoltage lockout with back-off
    assign uv_enter = stop_f && (uv_state == lps_pkg::UV_OK);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            uv_state <= lps_pkg::UV_OK;
            uv_cnt   <= 32'h0000_0000;
        end
        else
        begin
            case (uv_state)
                lps_pkg::UV_OK:
                begin
                    if (stop_f)
                        uv_state <= lps_pkg::UV_WAIT_START;
                end
                lps_pkg::UV_WAIT_START:
                begin
                    uv_cnt <= 32'h0000_0000;
                    if (!stop_f && start_f)
                        uv_state <= lps_pkg::UV_BACKOFF;
                end
                lps_pkg::UV_BACKOFF:
                begin
                    if (stop_f)
                        uv_state <= lps_pkg::UV_WAIT_START;
                    else if (uv_cnt >= BACKOFF_CYC - 32'h0000_0001)
                        uv_state <= lps_pkg::UV_OK;
                    else
                        uv_cnt <= uv_cnt + 32'h0000_0001;
                end
                default: uv_state <= lps_pkg::UV_OK;
            endcase
        end
    end

    // switching cycle
    assign leb_done  = on_cnt >= lps_pkg::LEB_CYC;
    assign peak_hit  = leb_done && peak_f;
    assign maxon_hit = on_cnt >= lps_pkg::MAXON_CYC - 16'h0001;
    assign valley_ok = (phase == lps_pkg::PH_SEC) && valley_f;
    assign off_timeout = (phase == lps_pkg::PH_SEC) && !valley_f
        && (off_cnt == lps_pkg::OFF_LIMIT_CYC - 16'h0001);

    always_comb
    begin
        next_phase = phase;
        case (phase)
            lps_pkg::PH_IDLE:
            begin
                if (switch_request && !any_stop)
                    next_phase = lps_pkg::PH_ON;
            end
            lps_pkg::PH_ON:
            begin
                if (any_stop || peak_hit || maxon_hit)
                    next_phase = lps_pkg::PH_SEC;
            end
            lps_pkg::PH_SEC:
            begin
                if (valley_f || off_timeout || any_stop)
                    next_phase = lps_pkg::PH_IDLE;
            end
            default: next_phase = lps_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase          <= lps_pkg::PH_IDLE;
            gate_drive_out <= 1'b0;
        end
        else
        begin
            phase          <= next_phase;
            gate_drive_out <= next_phase == lps_pkg::PH_ON;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            on_cnt  <= 16'h0000;
            off_cnt <= 16'h0000;
        end
        else
        begin
            if (next_phase == lps_pkg::PH_ON && phase == lps_pkg::PH_ON)
                on_cnt <= on_cnt + 16'h0001;
            else
                on_cnt <= 16'h0000;
            if (next_phase == lps_pkg::PH_SEC && phase == lps_pkg::PH_SEC)
                off_cnt <= off_cnt + 16'h0001;
            else
                off_cnt <= 16'h0000;
        end
    end

    // output short guard
    assign sh_trip = sh_run && !valley_ok
        && (sh_cnt >= SH_DET_CYC - 32'h0000_0001);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_run <= 1'b0;
            sh_cnt <= 32'h0000_0000;
        end
        else
        begin
            if (valley_ok || sh_trip)
            begin
                // expiry ends the timer too, else it would retrip at once
                sh_run <= 1'b0;
                sh_cnt <= 32'h0000_0000;
            end
            else if (sh_run)
                sh_cnt <= sh_cnt + 32'h0000_0001;
            else if (off_timeout)
                sh_run <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_state    <= lps_pkg::SH_NONE;
            sh_back_cnt <= 32'h0000_0000;
        end
        else
        begin
            case (sh_state)
                lps_pkg::SH_NONE:
                begin
                    sh_back_cnt <= 32'h0000_0000;
                    if (sh_trip)
                        sh_state <= lps_pkg::SH_BACKOFF;
                end
                lps_pkg::SH_BACKOFF:
                begin
                    if (sh_back_cnt >= SH_BACKOFF_CYC - 32'h0000_0001)
                        sh_state <= lps_pkg::SH_NONE;
                    else
                        sh_back_cnt <= sh_back_cnt + 32'h0000_0001;
                end
                default: sh_state <= lps_pkg::SH_NONE;
            endcase
        end
    end

    // overvoltage latch: only a power-off reset clears it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ovp_latch <= 1'b0;
        else if (over_f)
            ovp_latch <= 1'b1;
    end

    // overtemperature, self-clearing
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            heat_stop <= 1'b0;
        else if (trip_f)
            heat_stop <= 1'b1;
        else if (release_f)
            heat_stop <= 1'b0;
    end

    // mains loss: any edge of the sense flag is a crossing
    assign crossing   = mains_f ^ mains_d;
    assign mains_trip = !crossing
        && (mains_cnt >= MAINS_LOSS_CYC - 32'h0000_0001);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mains_d    <= 1'b0;
            mains_cnt  <= 32'h0000_0000;
            mains_stop <= 1'b0;
        end
        else
        begin
            mains_d <= mains_f;
            if (crossing)
            begin
                mains_cnt  <= 32'h0000_0000;
                mains_stop <= 1'b0;
            end
            else if (mains_trip)
                mains_stop <= 1'b1;
            else
                mains_cnt <= mains_cnt + 32'h0000_0001;
        end
    end

    assign any_stop = (uv_state != lps_pkg::UV_OK)
        || (sh_state != lps_pkg::SH_NONE) || ovp_latch || heat_stop
        || mains_stop || !run_enable;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hv_source_en <= 1'b0;
            standby_out  <= 1'b0;
        end
        else
        begin
            hv_source_en <= (uv_state != lps_pkg::UV_OK) || low_f;
            standby_out  <= any_stop;
        end
    end

    // apb: zero wait states, read data caught in the setup cycle
    logic access;
    logic setup;
    logic mapped;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign mapped  = (paddr == lps_pkg::CTRL_OFS)
        || (paddr == lps_pkg::STATUS_OFS) || (paddr == lps_pkg::EVENT_OFS);
    assign pready  = access;
    assign pslverr = access && !mapped;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            run_enable <= lps_pkg::CTRL_RESET[lps_pkg::CTRL_RUN_BIT];
        else if (access && pwrite && paddr == lps_pkg::CTRL_OFS)
            run_enable <= pwdata[lps_pkg::CTRL_RUN_BIT];
    end

    // sticky event log; a new event beats a clear in the same cycle
    assign ev_set = {mains_trip, trip_f && !heat_stop, over_f && !ovp_latch,
                     sh_trip, maxon_hit && phase == lps_pkg::PH_ON,
                     peak_hit && phase == lps_pkg::PH_ON, uv_enter};
    assign ev_clr = (access && pwrite && paddr == lps_pkg::EVENT_OFS)
        ? pwdata[lps_pkg::EV_W-1:0] : '0;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            events <= '0;
        else
            events <= (events & ~ev_clr) | ev_set;
    end

    logic [31:0] status_word;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[lps_pkg::EV_UV]    = uv_state != lps_pkg::UV_OK;
        status_word[lps_pkg::EV_SHORT] = sh_state != lps_pkg::SH_NONE;
        status_word[lps_pkg::EV_OVP]   = ovp_latch;
        status_word[lps_pkg::EV_HEAT]  = heat_stop;
        status_word[lps_pkg::EV_MAINS] = mains_stop;
        status_word[lps_pkg::ST_GATE]  = gate_drive_out;
        status_word[lps_pkg::ST_HV]    = hv_source_en;
        status_word[lps_pkg::ST_STBY]  = any_stop;
        status_word[lps_pkg::ST_TMR]   = sh_run;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            case (paddr)
                lps_pkg::CTRL_OFS:
                    prdata <= {31'h0000_0000, run_enable};
                lps_pkg::STATUS_OFS:
                    prdata <= status_word;
                lps_pkg::EVENT_OFS:
                    prdata <= {25'h000_0000, events};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// [test/lps_sequencer_properties.sv]
`timescale 1ns/1ps
module lps_props #(
    parameter logic [31:0] BACKOFF_CYC    = 32'd200,
    parameter logic [31:0] MAINS_LOSS_CYC = 32'd100
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // comparator flags
    input wire logic supply_stop_level,
    input wire logic supply_start_level,
    input wire logic supply_over_level,
    input wire logic current_sense_input,
    input wire logic heat_trip_level,
    input wire logic mains_sense_input,
    // drive and supply control
    input wire logic gate_drive_out,
    input wire logic hv_source_en,
    input wire logic standby_out
);
    logic [15:0] on_cnt;
    logic [31:0] st_cnt;
    logic [31:0] m_cnt;
    logic [2:0]  ov_run;
    logic        st_last;
    logic        m_last;
    logic        uv_seen;
    logic        ovp_hit;

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            on_cnt <= '0;
        else
            on_cnt <= gate_drive_out ? on_cnt + 16'd1 : 16'd0;

    // saturating, so a long idle start level never wraps back to small
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            st_last <= 1'b0;
            st_cnt  <= '0;
        end
        else
        begin
            st_last <= supply_start_level;
            if (supply_start_level && !st_last)
                st_cnt <= '0;
            else if (st_cnt != '1)
                st_cnt <= st_cnt + 32'd1;
        end

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            m_last <= 1'b0;
            m_cnt  <= '0;
        end
        else
        begin
            m_last <= mains_sense_input;
            if (mains_sense_input != m_last)
                m_cnt <= '0;
            else if (m_cnt != '1)
                m_cnt <= m_cnt + 32'd1;
        end

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            uv_seen <= 1'b0;
        else if (supply_stop_level)
            uv_seen <= 1'b1;
        else if (!standby_out)
            uv_seen <= 1'b0;

    // only a power-off clears this, as for the design
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            ov_run  <= '0;
            ovp_hit <= 1'b0;
        end
        else
        begin
            ov_run  <= supply_over_level ?
                       ov_run + {2'b0, ov_run != 3'd7} : 3'd0;
            ovp_hit <= ovp_hit | (ov_run == 3'd6);
        end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    gate_stop_a: assert property (standby_out |-> !gate_drive_out)
        else $error("gate high during a stop");
    blank_hold_a: assert property (gate_drive_out && !standby_out &&
        on_cnt < 16'd23 |=> gate_drive_out || standby_out)
        else $error("gate ended inside blanking");
    max_on_a: assert property (gate_drive_out |-> on_cnt < 16'd577)
        else $error("on-time beyond limit");
    peak_cut_a: assert property (gate_drive_out && on_cnt > 16'd30 &&
        current_sense_input |-> ##[1:6] !gate_drive_out)
        else $error("peak did not end on-time");
    uv_stop_a: assert property (supply_stop_level [*6] |=>
        hv_source_en && standby_out)
        else $error("no lockout on low supply");
    uv_backoff_a: assert property ($fell(standby_out) && uv_seen |->
        st_cnt >= BACKOFF_CYC)
        else $error("restart before back-off");
    ovp_latch_a: assert property (ovp_hit |->
        standby_out && !gate_drive_out)
        else $error("overvoltage stop not held");
    heat_stop_a: assert property (heat_trip_level [*6] |=> standby_out)
        else $error("no stop on heat trip");
    mains_loss_a: assert property (m_cnt > MAINS_LOSS_CYC + 32'd8 |->
        standby_out)
        else $error("no stop on mains loss");

    peak_c: cover property ($fell(gate_drive_out) && on_cnt > 16'd30 &&
        on_cnt < 16'd100);
    max_on_c: cover property (gate_drive_out && on_cnt == 16'd575);
    ovp_c: cover property (ovp_hit);
endmodule

bind lps_sequencer lps_props #(
    .BACKOFF_CYC   (BACKOFF_CYC),
    .MAINS_LOSS_CYC(MAINS_LOSS_CYC)
) u_props (.clk(clk), .nrst(nrst), .supply_stop_level(supply_stop_level),
    .supply_start_level(supply_start_level),
    .supply_over_level(supply_over_level),
    .current_sense_input(current_sense_input),
    .heat_trip_level(heat_trip_level), .mains_sense_input(mains_sense_input),
    .gate_drive_out(gate_drive_out), .hv_source_en(hv_source_en),
    .standby_out(standby_out));

// [test/lps_far_model.sv]
`timescale 1ns/1ps
module lps_far_model (
    // clock
    input  wire logic        clk,
    // gate from the block
    input  wire logic        gate_drive_out,
    // knobs in cycles, zero means never
    input  wire logic [15:0] peak_dly,
    input  wire logic [15:0] valley_dly,
    input  wire logic        spike_en,
    // comparator flags
    output logic             current_sense_input,
    output logic             valley_detect
);
    int on_t;
    int off_t;

    always @(posedge clk)
    begin
        on_t  <= gate_drive_out ? on_t + 1 : 0;
        off_t <= gate_drive_out ? 0 : off_t + 1;
    end

    // turn-on spike is long enough to pass the filter if not blanked
    always_comb
        current_sense_input = gate_drive_out &&
            ((spike_en && on_t < 6) || (peak_dly != 0 && on_t >= peak_dly));

    always_comb
        valley_detect = valley_dly != 0 && !gate_drive_out &&
            off_t >= valley_dly && off_t < valley_dly + 4;
endmodule

// [test/tb_lps_sequencer.sv]
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            n_errors++; \
            $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); \
        end \
    end
`define WAITV(c, n) \
    begin \
        wc = 0; \
        while (!(c) && wc < (n)) \
        begin \
            @(posedge clk); \
            wc++; \
        end \
    end
module tb_lps_sequencer;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        switch_request, stop_l, start_l, low_l, over_l;
    logic        trip_l, rel_l, mains_in, mains_on, spike_en;
    logic        sense, valley, gate, hv, stby;
    logic [15:0] peak_dly, valley_dly;
    int          n_errors = 0;
    int          n_compared = 0;
    int          wc;
    int          mc = 0;

    lps_sequencer #(.BACKOFF_CYC(32'd200), .SH_BACKOFF_CYC(32'd400),
        .SH_DET_CYC(32'd100), .MAINS_LOSS_CYC(32'd100)) DUT (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .switch_request(switch_request),
        .supply_stop_level(stop_l), .supply_start_level(start_l),
        .supply_low_level(low_l), .supply_over_level(over_l),
        .current_sense_input(sense), .valley_detect(valley),
        .heat_trip_level(trip_l), .heat_release_level(rel_l),
        .mains_sense_input(mains_in), .gate_drive_out(gate),
        .hv_source_en(hv), .standby_out(stby));

    lps_far_model far (.clk(clk), .gate_drive_out(gate),
        .peak_dly(peak_dly), .valley_dly(valley_dly), .spike_en(spike_en),
        .current_sense_input(sense), .valley_detect(valley));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        mc <= mc + 1;
        if (mains_on && mc % 30 == 0)
            mains_in <= ~mains_in;
    end

    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (!pready);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q & m, m)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        apb(1'b0, lps_pkg::CTRL_OFS, 32'h0, q, e);
        `CHK(q, lps_pkg::CTRL_RESET)
        apb(1'b0, 8'h40, 32'h0, q, e);
        `CHK({e, q}, 33'h1_0000_0000)
        wr(lps_pkg::EVENT_OFS, 32'h7f);
        apb(1'b0, lps_pkg::EVENT_OFS, 32'h0, q, e);
        `CHK(q & 32'h7f, 32'h0)
        $display("t_regs done");
    endtask

    task automatic t_peak;
        switch_request <= 1'b1;
        `WAITV(gate, 50)
        `WAITV(!gate, 700)
        `CHK(wc >= 40 && wc <= 48, 1'b1)
        rdm(lps_pkg::EVENT_OFS, 1 << lps_pkg::EV_PEAK);
        wr(lps_pkg::CTRL_OFS, 32'h0);
        repeat (3) @(posedge clk);
        `CHK({gate, stby}, 2'b01)
        wr(lps_pkg::CTRL_OFS, 32'h1);
        $display("t_peak done");
    endtask

    task automatic t_maxon;
        peak_dly <= 16'd0;
        spike_en <= 1'b0;
        `WAITV(!gate, 700)
        `WAITV(gate, 1000)
        `WAITV(!gate, 700)
        `CHK(wc >= 575 && wc <= 578, 1'b1)
        rdm(lps_pkg::EVENT_OFS, 1 << lps_pkg::EV_MAXON);
        peak_dly <= 16'd40;
        $display("t_maxon done");
    endtask

    task automatic t_uv;
        stop_l  <= 1'b1;
        start_l <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK({hv, stby, gate}, 3'b110)
        stop_l <= 1'b0;
        repeat (5) @(posedge clk);
        start_l <= 1'b1;
        `WAITV(!stby, 600)
        `CHK(wc >= 200 && wc <= 215, 1'b1)
        low_l <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK({hv, stby}, 2'b10)
        low_l <= 1'b0;
        $display("t_uv done");
    endtask

    task automatic t_heat;
        trip_l <= 1'b1;
        rel_l  <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(stby, 1'b1)
        trip_l <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(stby, 1'b1)
        rel_l <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(stby, 1'b0)
        $display("t_heat done");
    endtask

    task automatic t_mains;
        mains_on <= 1'b0;
        repeat (60) @(posedge clk);
        `CHK(stby, 1'b0)
        repeat (80) @(posedge clk);
        `CHK(stby, 1'b1)
        mains_on <= 1'b1;
        repeat (40) @(posedge clk);
        `CHK(stby, 1'b0)
        $display("t_mains done");
    endtask

    task automatic t_short;
        valley_dly <= 16'd0;
        `WAITV(stby, 3000)
        `CHK(stby, 1'b1)
        rdm(lps_pkg::EVENT_OFS, 1 << lps_pkg::EV_SHORT);
        `WAITV(!stby, 1000)
        `CHK(wc >= 395 && wc <= 420, 1'b1)
        valley_dly <= 16'd20;
        $display("t_short done");
    endtask

    task automatic t_ovp;
        over_l <= 1'b1;
        repeat (10) @(posedge clk);
        over_l <= 1'b0;
        repeat (300) @(posedge clk);
        `CHK({stby, gate}, 2'b10)
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(stby, 1'b0)
        $display("t_ovp done");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        {nrst, psel, penable, pwrite, switch_request} = 5'b0;
        {paddr, pwdata} = 40'h0;
        {stop_l, start_l, low_l, over_l, trip_l, rel_l} = 6'b010001;
        {mains_in, mains_on, spike_en} = 3'b011;
        peak_dly = 16'd40;
        valley_dly = 16'd20;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_peak();
        t_maxon();
        t_uv();
        t_heat();
        t_mains();
        t_short();
        t_ovp();
        give_verdict();
    end
endmodule
